/* File: inc/dpt_defines.svh */
// offsets, field positions, reset values and port framing for the pll tuning bank
`ifndef DPT_DEFINES_SVH
`define DPT_DEFINES_SVH

`define DPT_ADDR_W 15
`define DPT_ADDR_DETECTOR 15'h01b1
`define DPT_ADDR_AMPLITUDE 15'h01b2
`define DPT_ADDR_BAND_LOW 15'h01b3
`define DPT_ADDR_BAND_CTRL 15'h01b4
`define DPT_ADDR_SWEEP 15'h01b5
`define DPT_ADDR_OSC 15'h01b6
`define DPT_ADDR_RECAL 15'h01b7
`define DPT_ADDR_STATUS 15'h01b8

`define DPT_DLY_LSB 2
`define DPT_EDGE_BIT 1
`define DPT_AMP_OVR_BIT 7
`define DPT_LOAD_BYP_BIT 7
`define DPT_CAL_OFS_LSB 3
`define DPT_BAND_OVR_BIT 1
`define DPT_BAND_TOP_BIT 0
`define DPT_SWEEP_LSB 4
`define DPT_OSC_RST_BIT 6
`define DPT_OSC_SEL_LSB 4
`define DPT_RECAL_BIT 7
`define DPT_COMP_BIT 6
`define DPT_DONE_BIT 5
`define DPT_BUSY_BIT 4

`define DPT_RST_DLY 2'h1
`define DPT_RST_CAL_OFS 4'hf
`define DPT_RST_SWEEP 4'h8
`define DPT_RST_OSC_RST 1'h1
`define DPT_RST_OSC_LVL 4'ha

`define DPT_INSTR_LAST 4'hf
`define DPT_BYTE_LAST 4'h7
`define DPT_RW_BIT 15

`endif

/* File: inc/dpt_pkg.sv */
// types shared by the pll tuning register bank
package dpt_pkg;
    typedef logic [7:0] dpt_byte_t;
    typedef enum logic [1:0] {
        DPT_ST_INSTR = 2'b01,
        DPT_ST_DATA = 2'b10
    } dpt_state_e;
endpackage : dpt_pkg

/* File: inc/dpt_serial_if.sv */
// synchronised serial port events passed from the pin front end to the bank
`timescale 1ns/1ps
interface dpt_serial_if;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic data_bit;
    modport front (output sclk_rise, output sclk_fall, output selected, output data_bit);
    modport bank (input sclk_rise, input sclk_fall, input selected, input data_bit);
endinterface : dpt_serial_if

/* File: verilog/dpt_spi_front.sv */
// pin synchronisers and clock edge detection for the serial programming port
`timescale 1ns/1ps
module dpt_spi_front (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdio_in,
    dpt_serial_if.front port
);
    // stage 0 feeds stage 1 only; everything downstream reads stage 1 and later
    logic [2:0] sync_0;
    logic [2:0] sync_1;
    logic sclk_prev;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_0 <= 3'h6;
            sync_1 <= 3'h6;
            sclk_prev <= 1'b1;
        end else begin
            sync_0 <= {spi_cs_n, spi_sclk, spi_sdio_in};
            sync_1 <= sync_0;
            sclk_prev <= sync_1[1];
        end
    end

    assign port.selected = ~sync_1[2];
    assign port.sclk_rise = port.selected & sync_1[1] & ~sclk_prev;
    assign port.sclk_fall = port.selected & ~sync_1[1] & sclk_prev;
    assign port.data_bit = sync_1[0];
endmodule : dpt_spi_front

/* File: verilog/dpt_pll_tuning_regs.sv */
// pll tuning register bank behind the serial programming port
`timescale 1ns/1ps
`include "dpt_defines.svh"
module dpt_pll_tuning_regs
    import dpt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe,
    input wire logic [6:0] auto_amplitude_word,
    input wire logic [8:0] auto_band,
    input wire logic pump_cal_done_in,
    input wire logic pump_comparator_in,
    input wire logic oscillator_cal_busy_in,
    input wire logic [3:0] pump_cal_code_in,
    output logic [1:0] detector_delay_select,
    output logic detector_edge_select,
    output logic amplitude_override_enable,
    output logic [6:0] amplitude_word,
    output logic band_override_enable,
    output logic [8:0] tuning_band,
    output logic load_delay_bypass,
    output logic [3:0] calibration_start_offset,
    output logic [3:0] amplitude_sweep_start,
    output logic oscillator_logic_reset,
    output logic [1:0] oscillator_bit_select,
    output logic [3:0] oscillator_level,
    output logic synth_manual_recal,
    output logic synth_recal_start,
    output logic [5:0] pump_bleed_offset
);
    dpt_serial_if port ();

    dpt_spi_front dpt_spi_front_i (
        .clk(clk),
        .resetn(resetn),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdio_in(spi_sdio_in),
        .port(port)
    );

    // serial protocol: 16-bit instruction, then streamed data bytes
    dpt_state_e state;
    dpt_state_e next_state;
    logic [3:0] bit_cnt;
    logic [15:0] instr_sr;
    logic [6:0] data_sr;
    logic read_mode;
    logic [14:0] addr;
    dpt_byte_t rd_shift;

    wire instr_done = (state == DPT_ST_INSTR) & port.sclk_rise & (bit_cnt == `DPT_INSTR_LAST);
    wire byte_done = (state == DPT_ST_DATA) & port.sclk_rise & (bit_cnt == `DPT_BYTE_LAST);
    wire [15:0] instr_word = {instr_sr[14:0], port.data_bit};
    wire dpt_byte_t wdata = {data_sr, port.data_bit};
    wire wr_strobe = byte_done & ~read_mode;
    // the direction bit of a fresh instruction steers the pin at once, so a write
    // that follows a read never drives the data line for a stray cycle
    wire next_read_mode = instr_done ? instr_word[`DPT_RW_BIT] : read_mode;

    always_comb begin
        next_state = state;
        case (state)
            DPT_ST_INSTR: begin
                if (instr_done) begin
                    next_state = DPT_ST_DATA;
                end
            end
            DPT_ST_DATA: next_state = DPT_ST_DATA;
            default: next_state = DPT_ST_INSTR;
        endcase
        if (!port.selected) begin
            next_state = DPT_ST_INSTR;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= DPT_ST_INSTR;
        end else begin
            state <= next_state;
        end
    end

    // a deselect mid-byte drops the partial byte; nothing is committed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= 4'h0;
        end else if (!port.selected || instr_done || byte_done) begin
            bit_cnt <= 4'h0;
        end else if (port.sclk_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            instr_sr <= 16'h0000;
            data_sr <= 7'h00;
        end else if (port.sclk_rise) begin
            instr_sr <= instr_word;
            data_sr <= wdata[6:0];
        end
    end

    // streaming walks upward one address per byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            read_mode <= 1'b0;
            addr <= 15'h0000;
        end else if (instr_done) begin
            read_mode <= instr_word[`DPT_RW_BIT];
            addr <= instr_word[14:0];
        end else if (byte_done) begin
            addr <= addr + 15'h0001;
        end
    end

    // status synchronisers: analog calibration runs on its own timing
    localparam int NSTAT = 7;
    logic [NSTAT-1:0] stat_async;
    logic [NSTAT-1:0] stat_0;
    logic [NSTAT-1:0] stat_1;

    assign stat_async = {pump_comparator_in, pump_cal_done_in, oscillator_cal_busy_in,
                         pump_cal_code_in};

    // code bits cross one by one; read the code only once done is seen set
    genvar gi;
    generate
        for (gi = 0; gi < NSTAT; gi++) begin : g_stat_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stat_0[gi] <= 1'b0;
                    stat_1[gi] <= 1'b0;
                end else begin
                    stat_0[gi] <= stat_async[gi];
                    stat_1[gi] <= stat_0[gi];
                end
            end
        end
    endgenerate

    // write decode
    wire wr_det = wr_strobe & (addr == `DPT_ADDR_DETECTOR);
    wire wr_amp = wr_strobe & (addr == `DPT_ADDR_AMPLITUDE);
    wire wr_blo = wr_strobe & (addr == `DPT_ADDR_BAND_LOW);
    wire wr_bct = wr_strobe & (addr == `DPT_ADDR_BAND_CTRL);
    wire wr_swp = wr_strobe & (addr == `DPT_ADDR_SWEEP);
    wire wr_osc = wr_strobe & (addr == `DPT_ADDR_OSC);
    wire wr_rcl = wr_strobe & (addr == `DPT_ADDR_RECAL);

    logic [6:0] forced_amplitude_word;
    logic [7:0] forced_band_low;
    logic forced_band_top;

    // only defined field bits are stored, so reserved positions never hold state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            detector_delay_select <= `DPT_RST_DLY;
            detector_edge_select <= 1'b0;
        end else if (wr_det) begin
            detector_delay_select <= wdata[`DPT_DLY_LSB +: 2];
            detector_edge_select <= wdata[`DPT_EDGE_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            amplitude_override_enable <= 1'b0;
            forced_amplitude_word <= 7'h00;
        end else if (wr_amp) begin
            amplitude_override_enable <= wdata[`DPT_AMP_OVR_BIT];
            forced_amplitude_word <= wdata[6:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            forced_band_low <= 8'h00;
        end else if (wr_blo) begin
            forced_band_low <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            load_delay_bypass <= 1'b0;
            calibration_start_offset <= `DPT_RST_CAL_OFS;
            band_override_enable <= 1'b0;
            forced_band_top <= 1'b0;
        end else if (wr_bct) begin
            load_delay_bypass <= wdata[`DPT_LOAD_BYP_BIT];
            calibration_start_offset <= wdata[`DPT_CAL_OFS_LSB +: 4];
            band_override_enable <= wdata[`DPT_BAND_OVR_BIT];
            forced_band_top <= wdata[`DPT_BAND_TOP_BIT];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            amplitude_sweep_start <= `DPT_RST_SWEEP;
        end else if (wr_swp) begin
            amplitude_sweep_start <= wdata[`DPT_SWEEP_LSB +: 4];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oscillator_logic_reset <= `DPT_RST_OSC_RST;
            oscillator_bit_select <= 2'h0;
            oscillator_level <= `DPT_RST_OSC_LVL;
        end else if (wr_osc) begin
            oscillator_logic_reset <= wdata[`DPT_OSC_RST_BIT];
            oscillator_bit_select <= wdata[`DPT_OSC_SEL_LSB +: 2];
            oscillator_level <= wdata[3:0];
        end
    end

    // a rising write of the recal bit also fires a one-cycle start pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            synth_manual_recal <= 1'b0;
            synth_recal_start <= 1'b0;
            pump_bleed_offset <= 6'h00;
        end else begin
            synth_recal_start <= wr_rcl & wdata[`DPT_RECAL_BIT] & ~synth_manual_recal;
            if (wr_rcl) begin
                synth_manual_recal <= wdata[`DPT_RECAL_BIT];
                pump_bleed_offset <= wdata[5:0];
            end
        end
    end

    // applied words: override muxes, registered so outputs come from flops
    wire [6:0] next_amplitude_word = amplitude_override_enable ? forced_amplitude_word
                                                               : auto_amplitude_word;
    wire [8:0] next_tuning_band = band_override_enable ? {forced_band_top, forced_band_low}
                                                       : auto_band;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            amplitude_word <= 7'h00;
            tuning_band <= 9'h000;
        end else begin
            amplitude_word <= next_amplitude_word;
            tuning_band <= next_tuning_band;
        end
    end

    // readback: write-only and reserved bits read as zero
    dpt_byte_t rb_det;
    dpt_byte_t rb_amp;
    dpt_byte_t rb_bct;
    dpt_byte_t rb_swp;
    dpt_byte_t rb_osc;
    dpt_byte_t rb_rcl;
    dpt_byte_t rb_sts;

    always_comb begin
        rb_det = 8'h00;
        rb_det[`DPT_DLY_LSB +: 2] = detector_delay_select;
        rb_det[`DPT_EDGE_BIT] = detector_edge_select;
        rb_amp = 8'h00;
        rb_amp[`DPT_AMP_OVR_BIT] = amplitude_override_enable;
        rb_bct = 8'h00;
        rb_bct[`DPT_LOAD_BYP_BIT] = load_delay_bypass;
        rb_bct[`DPT_CAL_OFS_LSB +: 4] = calibration_start_offset;
        rb_bct[`DPT_BAND_OVR_BIT] = band_override_enable;
        rb_swp = 8'h00;
        rb_swp[`DPT_SWEEP_LSB +: 4] = amplitude_sweep_start;
        rb_osc = 8'h00;
        rb_osc[`DPT_OSC_RST_BIT] = oscillator_logic_reset;
        rb_osc[`DPT_OSC_SEL_LSB +: 2] = oscillator_bit_select;
        rb_osc[3:0] = oscillator_level;
        rb_rcl = 8'h00;
        rb_rcl[`DPT_RECAL_BIT] = synth_manual_recal;
        rb_rcl[5:0] = pump_bleed_offset;
        rb_sts = 8'h00;
        rb_sts[`DPT_COMP_BIT] = stat_1[6];
        rb_sts[`DPT_DONE_BIT] = stat_1[5];
        rb_sts[`DPT_BUSY_BIT] = stat_1[4];
        rb_sts[3:0] = stat_1[3:0];
    end

    wire dpt_byte_t rd_data =
        (addr == `DPT_ADDR_DETECTOR) ? rb_det :
        (addr == `DPT_ADDR_AMPLITUDE) ? rb_amp :
        (addr == `DPT_ADDR_BAND_CTRL) ? rb_bct :
        (addr == `DPT_ADDR_SWEEP) ? rb_swp :
        (addr == `DPT_ADDR_OSC) ? rb_osc :
        (addr == `DPT_ADDR_RECAL) ? rb_rcl :
        (addr == `DPT_ADDR_STATUS) ? rb_sts : 8'h00;

    // load a byte on the first falling edge of each data byte, shift on the rest
    wire rd_load = (state == DPT_ST_DATA) & read_mode & port.sclk_fall & (bit_cnt == 4'h0);
    wire rd_step = (state == DPT_ST_DATA) & read_mode & port.sclk_fall & (bit_cnt != 4'h0);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_shift <= 8'h00;
        end else if (rd_load) begin
            rd_shift <= rd_data;
        end else if (rd_step) begin
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spi_sdio_out <= 1'b0;
            spi_sdio_oe <= 1'b0;
        end else begin
            spi_sdio_out <= rd_load ? rd_data[7] : rd_shift[7];
            if (rd_step) begin
                spi_sdio_out <= rd_shift[6];
            end
            spi_sdio_oe <= (next_state == DPT_ST_DATA) & next_read_mode & port.selected;
        end
    end
endmodule : dpt_pll_tuning_regs

/* File: test/dpt_pll_tuning_regs_checker.sv */
// port assertions for the pll tuning register bank
`timescale 1ns/1ps
module dpt_pll_tuning_regs_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [6:0] auto_amplitude_word,
    input wire logic [8:0] auto_band,
    input wire logic amplitude_override_enable,
    input wire logic [6:0] amplitude_word,
    input wire logic band_override_enable,
    input wire logic [8:0] tuning_band,
    input wire logic [3:0] calibration_start_offset,
    input wire logic [3:0] amplitude_sweep_start,
    input wire logic oscillator_logic_reset,
    input wire logic synth_manual_recal,
    input wire logic synth_recal_start
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // applied words lag the select by one flop
    amp_auto_a:
        assert property (!amplitude_override_enable |=>
            amplitude_word == $past(auto_amplitude_word)) else $error("amplitude word not auto");
    amp_forced_a:
        assert property (amplitude_override_enable [*3] |-> $stable(amplitude_word))
        else $error("forced amplitude word moved");
    band_auto_a:
        assert property (!band_override_enable |=> tuning_band == $past(auto_band))
        else $error("tuning band not auto");
    band_forced_a:
        assert property (band_override_enable [*3] |-> $stable(tuning_band))
        else $error("forced tuning band moved");
    ofs_reset_a:
        assert property ($rose(resetn) |-> calibration_start_offset == 4'hf)
        else $error("start offset reset value wrong");
    sweep_reset_a:
        assert property ($rose(resetn) |-> amplitude_sweep_start == 4'h8)
        else $error("sweep start reset value wrong");
    osc_reset_a:
        assert property ($rose(resetn) |-> oscillator_logic_reset && !synth_manual_recal)
        else $error("oscillator reset or recal reset value wrong");
    recal_pulse_a:
        assert property ($rose(synth_manual_recal) |-> ##[0:1] synth_recal_start ##1
            !synth_recal_start) else $error("recal start pulse missing or long");
    amp_forced_c: cover property (amplitude_override_enable [*3]);
    band_forced_c: cover property (band_override_enable [*3]);
    recal_c: cover property (synth_recal_start);
endmodule : dpt_pll_tuning_regs_checker

bind dpt_pll_tuning_regs dpt_pll_tuning_regs_checker dpt_pll_tuning_regs_checker_i (
    .clk(clk), .resetn(resetn), .auto_amplitude_word(auto_amplitude_word),
    .auto_band(auto_band), .amplitude_override_enable(amplitude_override_enable),
    .amplitude_word(amplitude_word), .band_override_enable(band_override_enable),
    .tuning_band(tuning_band), .calibration_start_offset(calibration_start_offset),
    .amplitude_sweep_start(amplitude_sweep_start),
    .oscillator_logic_reset(oscillator_logic_reset),
    .synth_manual_recal(synth_manual_recal), .synth_recal_start(synth_recal_start)
);

/* File: test/dpt_pll_tuning_regs_test.sv */
// self-checking bench for the pll tuning register bank
`timescale 1ns/1ps
module dpt_pll_tuning_regs_test;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic spi_sclk = 1'b0;
    logic spi_cs_n = 1'b1;
    logic spi_sdio_in = 1'b0;
    logic [6:0] auto_amplitude_word = 7'h15;
    logic [8:0] auto_band = 9'h0c3;
    logic pump_cal_done_in = 1'b0;
    logic pump_comparator_in = 1'b0;
    logic oscillator_cal_busy_in = 1'b0;
    logic [3:0] pump_cal_code_in = 4'h0;
    logic spi_sdio_out, spi_sdio_oe, detector_edge_select, amplitude_override_enable;
    logic band_override_enable, load_delay_bypass, oscillator_logic_reset;
    logic synth_manual_recal, synth_recal_start;
    logic [1:0] detector_delay_select, oscillator_bit_select;
    logic [6:0] amplitude_word;
    logic [8:0] tuning_band;
    logic [3:0] calibration_start_offset, amplitude_sweep_start, oscillator_level;
    logic [5:0] pump_bleed_offset;
    logic [7:0] rd;
    int num_errors = 0;
    int tests_run = 0;
    int pulses = 0;

    dpt_pll_tuning_regs dpt_pll_tuning_regs_i (
        .clk, .resetn, .spi_sclk, .spi_cs_n, .spi_sdio_in, .spi_sdio_out, .spi_sdio_oe,
        .auto_amplitude_word, .auto_band, .pump_cal_done_in, .pump_comparator_in,
        .oscillator_cal_busy_in, .pump_cal_code_in, .detector_delay_select,
        .detector_edge_select, .amplitude_override_enable, .amplitude_word,
        .band_override_enable, .tuning_band, .load_delay_bypass, .calibration_start_offset,
        .amplitude_sweep_start, .oscillator_logic_reset, .oscillator_bit_select,
        .oscillator_level, .synth_manual_recal, .synth_recal_start, .pump_bleed_offset
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    // counted mid-cycle, where the pulse flop has settled
    always @(negedge clk) begin
        if (synth_recal_start === 1'b1) pulses++;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // six clocks per sclk phase clears the two-flop sync plus edge detect
    task automatic frame(input logic [15:0] ins, input logic [7:0] wd);
        logic [23:0] sh;
        sh = {ins, wd};
        spi_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // released data line toggles so a stale value cannot pass
            spi_sdio_in = (ins[15] && i < 8) ? i[0] : sh[i];
            tick(6);
            if (ins[15] && i < 8) begin
                rd[i] = spi_sdio_out;
                check("sdio_oe", 9'h1, spi_sdio_oe);
            end
            spi_sclk = 1'b1;
            tick(6);
            spi_sclk = 1'b0;
        end
        tick(6);
        spi_cs_n = 1'b1;
        tick(6);
    endtask : frame

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        frame({1'b0, a}, d);
    endtask : wr

    task automatic rdchk(input string what, input logic [14:0] a, input logic [7:0] exp);
        frame({1'b1, a}, 8'h00);
        check(what, {1'b0, exp}, {1'b0, rd});
    endtask : rdchk

    task automatic t_reset;
        check("offset", 9'hf, calibration_start_offset);
        check("sweep", 9'h8, amplitude_sweep_start);
        check("osc_reset", 9'h1, oscillator_logic_reset);
        check("recal", 9'h0, synth_manual_recal);
        check("delay", 9'h1, detector_delay_select);
        check("level", 9'ha, oscillator_level);
        rdchk("detector", 15'h1b1, 8'h04);
        rdchk("band_ctrl", 15'h1b4, 8'h78);
        rdchk("osc", 15'h1b6, 8'h4a);
        rdchk("recal_reg", 15'h1b7, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_amp;
        check("auto_word", 9'h15, amplitude_word);
        wr(15'h1b2, 8'hea);
        check("amp_ovr", 9'h1, amplitude_override_enable);
        auto_amplitude_word = 7'h33;
        tick(2);
        check("forced_word", 9'h6a, amplitude_word);
        rdchk("amp_reg", 15'h1b2, 8'h80);
        wr(15'h1b2, 8'h00);
        check("auto_back", 9'h33, amplitude_word);
        $display("test amplitude done");
    endtask : t_amp

    task automatic t_band;
        check("auto_band", 9'h0c3, tuning_band);
        wr(15'h1b3, 8'h5a);
        wr(15'h1b4, 8'h87);
        check("forced_band", 9'h15a, tuning_band);
        check("offset_w", 9'h0, calibration_start_offset);
        check("bypass_w", 9'h1, load_delay_bypass);
        rdchk("band_low", 15'h1b3, 8'h00);
        rdchk("band_ctrl_w", 15'h1b4, 8'h82);
        auto_band = 9'h1f0;
        wr(15'h1b4, 8'h78);
        check("band_back", 9'h1f0, tuning_band);
        check("offset_back", 9'hf, calibration_start_offset);
        $display("test band done");
    endtask : t_band

    task automatic t_fields;
        wr(15'h1b5, 8'h3f);
        check("sweep_w", 9'h3, amplitude_sweep_start);
        rdchk("sweep_reg", 15'h1b5, 8'h30);
        wr(15'h1b6, 8'h80);
        check("osc_reset_w", 9'h0, oscillator_logic_reset);
        check("level_w", 9'h0, oscillator_level);
        rdchk("osc_reg", 15'h1b6, 8'h00);
        wr(15'h1b1, 8'hff);
        check("delay_w", 9'h3, detector_delay_select);
        check("edge_w", 9'h1, detector_edge_select);
        rdchk("detector_w", 15'h1b1, 8'h0e);
        // a second reset must restore the sweep start and oscillator reset written above
        resetn = 1'b0;
        tick(3);
        resetn = 1'b1;
        tick(4);
        check("sweep_rst", 9'h8, amplitude_sweep_start);
        check("osc_rst", 9'h1, oscillator_logic_reset);
        $display("test fields done");
    endtask : t_fields

    task automatic t_recal;
        wr(15'h1b7, 8'hff);
        check("recal_set", 9'h1, synth_manual_recal);
        check("pulses", 9'h1, 9'(pulses));
        check("bleed", 9'h3f, pump_bleed_offset);
        rdchk("recal_w", 15'h1b7, 8'hbf);
        wr(15'h1b7, 8'h80);
        wr(15'h1b7, 8'h00);
        wr(15'h1b7, 8'h80);
        check("pulses2", 9'h2, 9'(pulses));
        $display("test recal done");
    endtask : t_recal

    task automatic t_status;
        rdchk("status_idle", 15'h1b8, 8'h00);
        pump_cal_done_in = 1'b1;
        pump_comparator_in = 1'b1;
        oscillator_cal_busy_in = 1'b1;
        pump_cal_code_in = 4'h5;
        tick(4);
        rdchk("status_done", 15'h1b8, 8'h75);
        pump_comparator_in = 1'b0;
        tick(4);
        rdchk("status_comp", 15'h1b8, 8'h35);
        wr(15'h1b8, 8'hff);
        rdchk("status_wr", 15'h1b8, 8'h35);
        rdchk("unmapped", 15'h1b9, 8'h00);
        $display("test status done");
    endtask : t_status

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end

    initial begin
        tick(10);
        resetn = 1'b1;
        tick(4);
        t_reset();
        t_amp();
        t_band();
        t_fields();
        t_recal();
        t_status();
        give_verdict();
    end
endmodule : dpt_pll_tuning_regs_test
